// file: dcd_pkg.sv
// package for the dma command decoder: command codes, status layout, read targets
// assumes the host writes control bytes one at a time on mclk with a one-cycle strobe
// Functional notes
// [R1] every command except bus enable disables controller
// [R2] bits 7,1,0 set marks command byte
// [R3] reset clears interrupts, ready force, repeat, wait, timing
// [R4] reset keeps read sequence position
// [R5] host sends one reset, six on abort
// [R6] C7 and CB restore port timing
// [R7] load copies addresses, clears count, unforces ready
// [R8] destination counter loads on first destination count
// [R9] host precedes load or continue when inactive
// [R10] continue clears byte count, keeps addresses
// [R11] interrupt disable blocks, keeps pending latches
// [R12] interrupts start disabled; AB enables them
// [R13] return opcode re-enables interrupts automatically
// [R14] conditions latch while interrupts disabled
// [R15] A3 clears latches, unforces ready, disables
// [R16] ready interrupt latch blocks bus until B7; code lets it block requests only while ready is active
// [R17] host orders enable-after-return, enable, return
// [R18] BF points next read at status byte
// [R19] 8B sets status bits 4 and 5
// [R20] status bits: transfer, ready, not pending
// [R21] host disables before re-arming status flags
// [R22] transfer flag cleared only by load
// [R23] host issues load before force ready
// [R24] 87 enables bus requests, touches nothing else
// [R25] 83 blocks bus requests until enable
// [R26] B3 forces ready in burst or continuous; code forces it only when burst_mode is set
// [R27] BB loads read mask; A7 starts sequence
// [R28] undefined codes only disable controller
package dcd_pkg;
    localparam logic [7:0] DCD_GROUP_MASK   = 8'h83;
    localparam logic [7:0] DCD_GROUP_MATCH  = 8'h83;
    localparam logic [7:0] DCD_CMD_RESET    = 8'hc3;
    localparam logic [7:0] DCD_CMD_RST_A    = 8'hc7;
    localparam logic [7:0] DCD_CMD_RST_B    = 8'hcb;
    localparam logic [7:0] DCD_CMD_LOAD     = 8'hcf;
    localparam logic [7:0] DCD_CMD_CONT     = 8'hd3;
    localparam logic [7:0] DCD_CMD_INT_DIS  = 8'haf;
    localparam logic [7:0] DCD_CMD_INT_EN   = 8'hab;
    localparam logic [7:0] DCD_CMD_RST_DIS  = 8'ha3;
    localparam logic [7:0] DCD_CMD_EN_RET   = 8'hb7;
    localparam logic [7:0] DCD_CMD_RD_STAT  = 8'hbf;
    localparam logic [7:0] DCD_CMD_REINIT   = 8'h8b;
    localparam logic [7:0] DCD_CMD_BUS_EN   = 8'h87;
    localparam logic [7:0] DCD_CMD_BUS_DIS  = 8'h83;
    localparam logic [7:0] DCD_CMD_FORCE    = 8'hb3;
    localparam logic [7:0] DCD_CMD_MASK_NX  = 8'hbb;
    localparam logic [7:0] DCD_CMD_RD_SEQ   = 8'ha7;
    // status bit positions
    localparam int DCD_ST_XFER  = 0;
    localparam int DCD_ST_RDY   = 1;
    localparam int DCD_ST_NOPND = 3;
    localparam int DCD_ST_NOMAT = 4;
    localparam int DCD_ST_NOEOB = 5;
    localparam int DCD_RD_REGS  = 7;
    localparam logic [6:0] DCD_MASK_RST = 7'h7f;
    localparam logic [2:0] DCD_PTR_ZERO = 3'h0;
    localparam logic [2:0] DCD_PTR_ONE  = 3'h1;
    // one-hot command decode result
    typedef struct packed {
        logic reset, rst_a, rst_b, load, cont, int_dis, int_en, rst_dis;
        logic en_ret, rd_stat, reinit, bus_en, bus_dis, force_rdy, mask_nx, rd_seq;
    } dcd_cmd_type;
endpackage : dcd_pkg

// file: dcd_cmd_if.sv
// interface carrying one decoded command strobe set from decoder to core
// assumes both ends sit on mclk
`timescale 1ns/1ps
interface dcd_cmd_if;
    import dcd_pkg::*;
    logic        valid;
    dcd_cmd_type cmd;
    modport src (output valid, output cmd);
    modport dst (input valid, input cmd);
endinterface : dcd_cmd_if

// file: dcd_decode.sv
// combinational decode of a written control byte into command strobes
// assumes wr_stb is a one-cycle pulse on mclk; mask_next steers the byte to the read mask
`timescale 1ns/1ps
module dcd_decode
    import dcd_pkg::*;
(
    input  wire logic       wr_stb,
    input  wire logic [7:0] wr_data,
    input  wire logic       mask_next,
    output logic            is_group,
    dcd_cmd_if.src          cmd_o
);
    // group recognised on bits 7,1,0; a pending mask byte is never a command
    always_comb begin
        is_group = wr_stb && !mask_next && ((wr_data & DCD_GROUP_MASK) == DCD_GROUP_MATCH); // [R2]
        cmd_o.valid = is_group;
        cmd_o.cmd = '0; // unknown codes set nothing [R28]
        if (is_group) begin
            case (wr_data)
                DCD_CMD_RESET:   cmd_o.cmd.reset     = 1'b1;
                DCD_CMD_RST_A:   cmd_o.cmd.rst_a     = 1'b1;
                DCD_CMD_RST_B:   cmd_o.cmd.rst_b     = 1'b1;
                DCD_CMD_LOAD:    cmd_o.cmd.load      = 1'b1;
                DCD_CMD_CONT:    cmd_o.cmd.cont      = 1'b1;
                DCD_CMD_INT_DIS: cmd_o.cmd.int_dis   = 1'b1;
                DCD_CMD_INT_EN:  cmd_o.cmd.int_en    = 1'b1;
                DCD_CMD_RST_DIS: cmd_o.cmd.rst_dis   = 1'b1;
                DCD_CMD_EN_RET:  cmd_o.cmd.en_ret    = 1'b1;
                DCD_CMD_RD_STAT: cmd_o.cmd.rd_stat   = 1'b1;
                DCD_CMD_REINIT:  cmd_o.cmd.reinit    = 1'b1;
                DCD_CMD_BUS_EN:  cmd_o.cmd.bus_en    = 1'b1;
                DCD_CMD_BUS_DIS: cmd_o.cmd.bus_dis   = 1'b1;
                DCD_CMD_FORCE:   cmd_o.cmd.force_rdy = 1'b1;
                DCD_CMD_MASK_NX: cmd_o.cmd.mask_nx   = 1'b1;
                DCD_CMD_RD_SEQ:  cmd_o.cmd.rd_seq    = 1'b1;
                default:         cmd_o.cmd           = '0;
            endcase
        end
    end
endmodule : dcd_decode

// file: dcd_read_ptr.sv
// read register pointer: status select, masked sequence start and advance
// assumes rd_stb is a one-cycle host read pulse on mclk
`timescale 1ns/1ps
module dcd_read_ptr
    import dcd_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    input  wire logic       rd_stb,
    input  wire logic       mask_wr,
    input  wire logic [6:0] mask_data,
    dcd_cmd_if.dst          cmd_i,
    output logic [2:0]      ptr,
    output logic [6:0]      mask
);
    typedef struct packed {
        logic [2:0] ptr;
        logic [6:0] mask;
    } dcd_ptr_type;
    dcd_ptr_type st_r, st_nxt;

    // lowest selected register at or above a start index, zero if none
    function automatic logic [2:0] dcd_first(input logic [6:0] m, input logic [2:0] from);
        logic [2:0] r;
        r = DCD_PTR_ZERO;
        for (int i = DCD_RD_REGS - 1; i >= 0; i--) begin
            if (m[i] && (i >= int'(from))) r = i[2:0];
        end
        return r;
    endfunction : dcd_first

    // reset command leaves this pointer alone on purpose [R4]
    always_comb begin
        st_nxt = st_r;
        if (mask_wr) st_nxt.mask = mask_data; // [R27]
        if (cmd_i.valid && cmd_i.cmd.rd_stat) st_nxt.ptr = DCD_PTR_ZERO; // [R18]
        else if (cmd_i.valid && cmd_i.cmd.rd_seq) st_nxt.ptr = dcd_first(st_r.mask, DCD_PTR_ZERO); // [R27]
        else if (rd_stb) begin
            // advance wraps to the first selected register so the sequence repeats
            if (st_r.ptr == 3'(DCD_RD_REGS - 1) || (st_r.mask >> (st_r.ptr + DCD_PTR_ONE)) == '0)
                st_nxt.ptr = dcd_first(st_r.mask, DCD_PTR_ZERO);
            else
                st_nxt.ptr = dcd_first(st_r.mask, st_r.ptr + DCD_PTR_ONE);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) st_r <= '{ptr: DCD_PTR_ZERO, mask: DCD_MASK_RST};
        else if (ce) st_r <= st_nxt;
    end
    assign ptr  = st_nxt.ptr; // registered by the top
    assign mask = st_r.mask;
endmodule : dcd_read_ptr

// file: dcd_top.sv
// top of the dma command decoder: control latches, status byte, read data
// assumes all inputs are from logic on mclk except rdy_pin, which is synchronised here
`timescale 1ns/1ps
module dcd_top
    import dcd_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    input  wire logic       wr_stb,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_stb,
    input  wire logic       rdy_pin,
    input  wire logic       burst_mode,
    input  wire logic       search_int_en,
    input  wire logic       ior_mode,
    input  wire logic       match_evt,
    input  wire logic       eob_evt,
    input  wire logic       xfer_evt,
    input  wire logic       dest_first_cnt,
    input  wire logic       dest_fixed,
    input  wire logic       bus_release,
    input  wire logic       int_ack,
    input  wire logic       ret_opcode,
    input  wire logic       int_cond,
    output logic [7:0]      rd_data,
    output logic [2:0]      rd_sel,
    output logic            bus_req_en,
    output logic            bus_req_ok,
    output logic            int_en,
    output logic            int_out,
    output logic            int_pending,
    output logic            int_in_service,
    output logic            ready_int_latch,
    output logic            force_ready,
    output logic            auto_repeat_clr,
    output logic            wait_clr,
    output logic            port_a_std_timing,
    output logic            port_b_std_timing,
    output logic            src_load,
    output logic            dst_load,
    output logic            byte_cnt_clr
);
    typedef struct packed {
        logic       rdy_s1, rdy_s2;
        logic       mask_next;
        logic       bus_en, int_en, ip, interrupt_in_service_latch, ready_interrupt_latch, force_rdy;
        logic       dst_pend;
        logic       xfer, nomatch, noeob;
        logic       rep_clr, wait_clr, a_std, b_std, src_ld, dst_ld, cnt_clr;
        logic [7:0] rd_data;
        logic [2:0] rd_sel;
        logic       req_ok, int_out;
    } dcd_state_type;
    dcd_state_type s_r, s_nxt;

    dcd_cmd_if cmd_bus ();
    logic       is_group;
    logic [2:0] ptr;
    logic       mask_wr;
    logic       rdy;

    assign mask_wr = wr_stb && s_r.mask_next;
    assign rdy     = s_r.rdy_s2;

    dcd_decode u_decode (
        .wr_stb    (wr_stb),
        .wr_data   (wr_data),
        .mask_next (s_r.mask_next),
        .is_group  (is_group),
        .cmd_o     (cmd_bus.src)
    );

    dcd_read_ptr u_ptr (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .rd_stb    (rd_stb),
        .mask_wr   (mask_wr),
        .mask_data (wr_data[6:0]),
        .cmd_i     (cmd_bus.dst),
        .ptr       (ptr),
        .mask      ()
    );

    // all latch updates; events except search enable are applied after command clears so a same-cycle set wins
    always_comb begin
        dcd_cmd_type c;
        c = cmd_bus.cmd;
        s_nxt = s_r;
        s_nxt.rdy_s1 = rdy_pin;
        s_nxt.rdy_s2 = s_r.rdy_s1;
        // one-cycle strobes default low
        s_nxt.rep_clr = 1'b0;
        s_nxt.wait_clr = 1'b0;
        s_nxt.a_std = 1'b0;
        s_nxt.b_std = 1'b0;
        s_nxt.src_ld = 1'b0;
        s_nxt.dst_ld = 1'b0;
        s_nxt.cnt_clr = 1'b0;
        if (mask_wr) s_nxt.mask_next = 1'b0; // mask byte consumed [R27]
        if (search_int_en) s_nxt.int_en = 1'b1; // search-control base bit 5 [R12]
        if (is_group) begin
            // any byte of the group except enable disables first [R1] [R28]
            if (!c.bus_en) s_nxt.bus_en = 1'b0; // [R1]
            if (c.reset) begin
                s_nxt.int_en = 1'b0; // [R3]
                s_nxt.ip = 1'b0;
                s_nxt.interrupt_in_service_latch = 1'b0;
                s_nxt.ready_interrupt_latch = 1'b0;
                s_nxt.force_rdy = 1'b0;
                s_nxt.rep_clr = 1'b1;
                s_nxt.wait_clr = 1'b1;
                s_nxt.a_std = 1'b1;
                s_nxt.b_std = 1'b1;
                s_nxt.cnt_clr = 1'b1;
                s_nxt.nomatch = 1'b1;
                s_nxt.noeob = 1'b1;
            end
            if (c.rst_a) s_nxt.a_std = 1'b1; // [R6]
            if (c.rst_b) s_nxt.b_std = 1'b1; // [R6]
            if (c.load) begin
                s_nxt.src_ld = 1'b1; // [R7] [R8]
                s_nxt.dst_pend = !dest_fixed; // [R8]
                s_nxt.cnt_clr = 1'b1;
                s_nxt.force_rdy = 1'b0;
                s_nxt.xfer = 1'b0; // [R22]
                s_nxt.noeob = 1'b1;
            end
            if (c.cont) begin
                s_nxt.cnt_clr = 1'b1; // addresses untouched [R10]
                s_nxt.noeob = 1'b1;
            end
            if (c.int_dis) s_nxt.int_en = 1'b0; // ip and ius kept [R11]
            if (c.int_en) s_nxt.int_en = 1'b1; // [R12]
            if (c.rst_dis) begin
                s_nxt.interrupt_in_service_latch = 1'b0; // [R15]
                s_nxt.ip = 1'b0;
                s_nxt.force_rdy = 1'b0;
                s_nxt.int_en = 1'b0;
            end
            if (c.en_ret) s_nxt.ready_interrupt_latch = 1'b0; // [R16]
            if (c.reinit) begin
                s_nxt.nomatch = 1'b1; // [R19]
                s_nxt.noeob = 1'b1;
            end
            if (c.bus_en) s_nxt.bus_en = 1'b1; // [R24]
            if (c.bus_dis) s_nxt.bus_en = 1'b0; // [R25]
            if (c.force_rdy && burst_mode) s_nxt.force_rdy = 1'b1; // [R26]
            if (c.mask_nx) s_nxt.mask_next = 1'b1; // [R27]
        end
        // forced ready also ends on termination or bus release [R26]
        if (eob_evt || match_evt || bus_release) s_nxt.force_rdy = 1'b0;
        // destination counter waits for its first count [R8]
        if (s_r.dst_pend && dest_first_cnt) begin
            s_nxt.dst_ld = 1'b1;
            s_nxt.dst_pend = 1'b0;
        end
        if (xfer_evt) s_nxt.xfer = 1'b1;
        if (match_evt) s_nxt.nomatch = 1'b0;
        if (eob_evt) s_nxt.noeob = 1'b0;
        // condition latches regardless of enable [R14]
        if (int_cond) s_nxt.ip = 1'b1; // [R14]
        if (int_cond && ior_mode) s_nxt.ready_interrupt_latch = 1'b1; // [R16]
        if (int_ack && s_r.ip && s_r.int_en) begin
            s_nxt.interrupt_in_service_latch = 1'b1;
            s_nxt.ip = int_cond;
        end
        // return opcode ends service and re-enables [R13]
        if (ret_opcode && s_r.interrupt_in_service_latch) begin
            s_nxt.interrupt_in_service_latch = 1'b0;
            s_nxt.int_en = 1'b1; // [R13]
        end
        // ready interrupt latch blocks requests while ready is active [R16]
        s_nxt.req_ok = s_nxt.bus_en && !s_nxt.interrupt_in_service_latch && !(s_nxt.ready_interrupt_latch && rdy) && (rdy || s_nxt.force_rdy);
        s_nxt.int_out = s_nxt.ip && s_nxt.int_en && !s_nxt.interrupt_in_service_latch; // [R11]
        s_nxt.rd_sel = ptr;
        // status from next state so a write shows at once
        s_nxt.rd_data = '0;
        if (ptr == DCD_PTR_ZERO) begin
            s_nxt.rd_data[DCD_ST_XFER] = s_nxt.xfer; // [R20]
            s_nxt.rd_data[DCD_ST_RDY] = s_nxt.rdy_s2; // [R20]
            s_nxt.rd_data[DCD_ST_NOPND] = !s_nxt.ip; // [R20]
            s_nxt.rd_data[DCD_ST_NOMAT] = s_nxt.nomatch;
            s_nxt.rd_data[DCD_ST_NOEOB] = s_nxt.noeob;
        end
    end

    // interrupts and bus requests come up disabled [R12]
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.nomatch <= 1'b1;
            s_r.noeob <= 1'b1;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign rd_data           = s_r.rd_data;
    assign rd_sel            = s_r.rd_sel;
    assign bus_req_en        = s_r.bus_en;
    assign bus_req_ok        = s_r.req_ok;
    assign int_en            = s_r.int_en;
    assign int_out           = s_r.int_out;
    assign int_pending       = s_r.ip;
    assign int_in_service    = s_r.interrupt_in_service_latch;
    assign ready_int_latch   = s_r.ready_interrupt_latch;
    assign force_ready       = s_r.force_rdy;
    assign auto_repeat_clr   = s_r.rep_clr;
    assign wait_clr          = s_r.wait_clr;
    assign port_a_std_timing = s_r.a_std;
    assign port_b_std_timing = s_r.b_std;
    assign src_load          = s_r.src_ld;
    assign dst_load          = s_r.dst_ld;
    assign byte_cnt_clr      = s_r.cnt_clr;
endmodule : dcd_top

// file: dcd_props.sv
// checker for the command decoder top: command effects, interrupt latches, read pointer
// assumes it is bound into dcd_top and sees only that module's ports
`timescale 1ns/1ps
module dcd_props
    import dcd_pkg::*;
(
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       ce,
    input wire logic       wr_stb,
    input wire logic [7:0] wr_data,
    input wire logic       rd_stb,
    input wire logic       dest_first_cnt,
    input wire logic       dest_fixed,
    input wire logic       int_ack,
    input wire logic       ret_opcode,
    input wire logic       int_cond,
    input wire logic       search_int_en,
    input wire logic [2:0] rd_sel,
    input wire logic       bus_req_en,
    input wire logic       int_en,
    input wire logic       int_out,
    input wire logic       int_pending,
    input wire logic       int_in_service,
    input wire logic       ready_int_latch,
    input wire logic       force_ready,
    input wire logic       auto_repeat_clr,
    input wire logic       wait_clr,
    input wire logic       port_a_std_timing,
    input wire logic       port_b_std_timing,
    input wire logic       src_load,
    input wire logic       dst_load,
    input wire logic       byte_cnt_clr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic       mask_pend_r;
    logic       dst_pend_r;
    logic [6:0] mask_r;
    wire        cmd_wr = ce && wr_stb && !mask_pend_r;
    // same-cycle events except search enable win over clears, so command checks exclude them
    wire        quiet  = !(int_cond || int_ack || ret_opcode || search_int_en || dest_first_cnt || rd_stb);
    // shadow of the pending mask byte and of the armed destination load
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mask_pend_r <= 1'b0;
            dst_pend_r  <= 1'b0;
            mask_r      <= DCD_MASK_RST;
        end else if (ce) begin
            if (wr_stb && mask_pend_r) mask_r <= wr_data[6:0];
            if (wr_stb) mask_pend_r <= cmd_wr && wr_data == DCD_CMD_MASK_NX;
            if (cmd_wr && wr_data == DCD_CMD_LOAD) dst_pend_r <= !dest_fixed;
            else if (dest_first_cnt) dst_pend_r <= 1'b0;
        end
    end
    // lowest register index that the mask lets through
    function automatic logic [2:0] first_reg(input logic [6:0] m);
        first_reg = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (m[i]) first_reg = 3'(i);
        end
    endfunction : first_reg
    sequence s_cmd(logic [7:0] c);
        cmd_wr && wr_data == c && quiet;
    endsequence
    a_group_disables: assert property (cmd_wr && (wr_data & DCD_GROUP_MASK) == DCD_GROUP_MATCH
        && wr_data != DCD_CMD_BUS_EN |=> !bus_req_en) else $error("group byte left bus requests on");
    a_reset_cmd: assert property (s_cmd(DCD_CMD_RESET) |=> !int_en && !int_pending && !int_in_service
        && !force_ready && !ready_int_latch && auto_repeat_clr && wait_clr && port_a_std_timing
        && port_b_std_timing && rd_sel == $past(rd_sel)) else $error("reset command effects wrong");
    a_port_timing: assert property (cmd_wr && (wr_data == DCD_CMD_RST_A || wr_data == DCD_CMD_RST_B)
        |=> port_a_std_timing == ($past(wr_data) == DCD_CMD_RST_A)
        && port_b_std_timing == ($past(wr_data) == DCD_CMD_RST_B)) else $error("port timing pulse wrong");
    a_load_cmd: assert property (s_cmd(DCD_CMD_LOAD) |=> src_load && byte_cnt_clr && !force_ready && !dst_load)
        else $error("load command effects wrong");
    a_dst_first: assert property (ce && dest_first_cnt && !cmd_wr |=> dst_load == $past(dst_pend_r))
        else $error("destination load at wrong count");
    a_int_disable: assert property (s_cmd(DCD_CMD_INT_DIS) |=> !int_en && !int_out
        && int_pending == $past(int_pending) && int_in_service == $past(int_in_service))
        else $error("interrupt disable touched latches");
    a_ret_reenable: assert property (ce && ret_opcode && !wr_stb && int_in_service |=> int_en && !int_in_service)
        else $error("return opcode did not re-enable");
    a_latch_off: assert property (ce && int_cond && !int_en && !wr_stb && !search_int_en && !ret_opcode
        |=> int_pending && !int_out) else $error("condition not latched while disabled");
    a_reset_int: assert property (s_cmd(DCD_CMD_RST_DIS) |=> !int_pending && !int_in_service
        && !force_ready && !int_en) else $error("reset and disable effects wrong");
    a_bus_enable: assert property (s_cmd(DCD_CMD_BUS_EN) |=> bus_req_en && int_en == $past(int_en)
        && int_pending == $past(int_pending) && force_ready == $past(force_ready)
        && ready_int_latch == $past(ready_int_latch)) else $error("bus enable changed other state");
    a_read_seq: assert property (cmd_wr && wr_data == DCD_CMD_RD_SEQ && !rd_stb
        |=> rd_sel == first_reg(mask_r)) else $error("read sequence start wrong");
endmodule : dcd_props
bind dcd_top dcd_props i_dcd_props (.*);

// file: dcd_host.sv
// host model: writes control bytes and takes reads, one strobe per transfer
// assumes the bench calls its tasks from one process on mclk
`timescale 1ns/1ps
module dcd_host (
    input  wire logic       mclk,
    output logic            wr_stb,
    output logic [7:0]      wr_data,
    output logic            rd_stb
);
    initial begin
        wr_stb  = 1'b0;
        wr_data = 8'h00;
        rd_stb  = 1'b0;
    end
    // one byte, strobe for one cycle; idle bus shows the inverse, never a stale copy
    task automatic put_byte(input logic [7:0] b);
        @(posedge mclk);
        wr_stb  <= 1'b1;
        wr_data <= b;
        @(posedge mclk);
        wr_stb  <= 1'b0;
        wr_data <= ~b;
    endtask : put_byte
    // one read, the pointer moves on at the strobe edge
    task automatic take_read();
        @(posedge mclk);
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
    endtask : take_read
endmodule : dcd_host

// file: test_dcd_top.sv
// self-checking bench for the command decoder top with a host model on the write and read side
// assumes the package, interface, design modules, host model and checker compile first
`timescale 1ns/1ps
module test_dcd_top;
    import dcd_pkg::*;
    `define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
        $display("wrong value %s expected %h seen %h", what, exp, got); end end
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        ce = 1'b1;
    logic        rdy_pin = 1'b0;
    logic        burst_mode = 1'b0;
    logic        ior_mode = 1'b0;
    logic        dest_fixed = 1'b0;
    logic [8:0]  ev = 9'h000;
    logic        wr_stb, rd_stb, bus_req_en, bus_req_ok, int_en, int_out, int_pending, int_in_service;
    logic        ready_int_latch, force_ready, auto_repeat_clr, wait_clr, port_a_std_timing, port_b_std_timing;
    logic        src_load, dst_load, byte_cnt_clr;
    logic [7:0]  wr_data, rd_data;
    logic [2:0]  rd_sel;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    wire  [5:0]  cmd_outs = {bus_req_en, src_load, byte_cnt_clr, port_a_std_timing, port_b_std_timing, wait_clr};
    // command byte beside {bus enable, source load, count clear, port a, port b, wait clear}
    logic [13:0] rows [18] = '{{8'hc3, 6'h0f}, {8'hc7, 6'h04}, {8'hcb, 6'h02}, {8'hcf, 6'h18}, {8'hd3, 6'h08},
        {8'haf, 6'h00}, {8'hab, 6'h00}, {8'ha3, 6'h00}, {8'hb7, 6'h00}, {8'hbf, 6'h00}, {8'h8b, 6'h00},
        {8'h83, 6'h00}, {8'hb3, 6'h00}, {8'ha7, 6'h00}, {8'h8f, 6'h00}, {8'h87, 6'h20}, {8'h80, 6'h20},
        {8'h03, 6'h20}};
    // events: 0 cond, 1 ack, 2 return, 3 search enable, 4 match, 5 block end, 6 transfer, 7 dest count, 8 release
    dcd_top i_dcd_top (.*, .int_cond(ev[0]), .int_ack(ev[1]), .ret_opcode(ev[2]), .search_int_en(ev[3]),
        .match_evt(ev[4]), .eob_evt(ev[5]), .xfer_evt(ev[6]), .dest_first_cnt(ev[7]), .bus_release(ev[8]));
    dcd_host i_dcd_host (.mclk(mclk), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb));
    always #20 mclk = ~mclk;
    // hang guard: the whole run needs well under this many cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // outputs are looked at on the falling edge after the taking edge
    task automatic wr(input logic [7:0] b);
        i_dcd_host.put_byte(b);
        @(negedge mclk);
    endtask : wr
    task automatic rd();
        i_dcd_host.take_read();
        @(negedge mclk);
    endtask : rd
    task automatic pulse(input int k);
        @(posedge mclk);
        ev[k] <= 1'b1;
        @(posedge mclk);
        ev[k] <= 1'b0;
        @(negedge mclk);
    endtask : pulse
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        wr(DCD_CMD_RESET);
        // every command except BB from bus-enabled state, so each disable shows
        for (int i = 0; i < 18; i++) begin
            wr(DCD_CMD_BUS_EN);
            wr(rows[i][13:6]);
            `CHK("command outputs", rows[i][5:0], cmd_outs)
        end
        // second reset in mid-run
        @(posedge mclk) sys_rst <= 1'b1;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(negedge mclk);
        `CHK("reset state", 2'b00, {bus_req_en, int_en})
        `CHK("reset status", 8'h38, rd_data)
        repeat (6) wr(DCD_CMD_RESET);
        pulse(0);
        `CHK("pending while disabled", 2'b10, {int_pending, int_out})
        `CHK("status pending bit", 1'b0, rd_data[3])
        wr(DCD_CMD_INT_EN);
        `CHK("int out after enable", 1'b1, int_out)
        wr(DCD_CMD_INT_DIS);
        `CHK("disable keeps pending", 2'b10, {int_pending, int_out})
        wr(DCD_CMD_INT_EN);
        pulse(1);
        `CHK("in service", 2'b10, {int_in_service, int_out})
        wr(DCD_CMD_EN_RET);
        wr(DCD_CMD_BUS_EN);
        pulse(2);
        `CHK("return re-enables", 2'b10, {int_en, int_in_service})
        pulse(0);
        wr(DCD_CMD_RST_DIS);
        `CHK("reset and disable", 4'h8, {rd_data[3], int_pending, int_in_service, int_en})
        pulse(3);
        `CHK("search enable", 1'b1, int_en)
        // force ready only in burst mode; release and load drop it
        wr(DCD_CMD_LOAD);
        wr(DCD_CMD_FORCE);
        `CHK("force outside burst", 1'b0, force_ready)
        @(posedge mclk) burst_mode <= 1'b1;
        wr(DCD_CMD_FORCE);
        wr(DCD_CMD_BUS_EN);
        `CHK("forced and enabled", 3'h7, {force_ready, bus_req_en, bus_req_ok})
        pulse(8);
        `CHK("release unforces", 2'b00, {force_ready, bus_req_ok})
        wr(DCD_CMD_FORCE);
        wr(DCD_CMD_LOAD);
        `CHK("load unforces", 1'b0, force_ready)
        @(posedge mclk) begin
            ior_mode <= 1'b1;
            rdy_pin  <= 1'b1;
        end
        pulse(0);
        wr(DCD_CMD_BUS_EN);
        `CHK("ready latch blocks", 3'h6, {ready_int_latch, bus_req_en, bus_req_ok})
        `CHK("status ready bit", 1'b1, rd_data[1])
        wr(DCD_CMD_EN_RET);
        wr(DCD_CMD_BUS_EN);
        `CHK("ready latch cleared", 2'b01, {ready_int_latch, bus_req_ok})
        // transfer flag survives all but load; match and block end re-armed
        pulse(6);
        wr(DCD_CMD_RESET);
        `CHK("transfer after reset", 1'b1, rd_data[0])
        pulse(4);
        pulse(5);
        `CHK("match and block end", 2'b00, rd_data[5:4])
        wr(DCD_CMD_BUS_DIS);
        wr(DCD_CMD_REINIT);
        `CHK("reinit flags", 3'h7, {rd_data[5:4], rd_data[0]})
        wr(DCD_CMD_LOAD);
        `CHK("load clears transfer", 1'b0, rd_data[0])
        pulse(7);
        `CHK("first dest count", 1'b1, dst_load)
        pulse(7);
        `CHK("second dest count", 1'b0, dst_load)
        @(posedge mclk) dest_fixed <= 1'b1;
        wr(DCD_CMD_LOAD);
        pulse(7);
        `CHK("fixed dest count", 1'b0, dst_load)
        // a group-looking mask byte is no command; the sequence wraps
        wr(DCD_CMD_MASK_NX);
        wr(DCD_CMD_BUS_EN);
        `CHK("mask byte not command", 1'b0, bus_req_en)
        wr(DCD_CMD_RD_SEQ);
        for (int i = 0; i < 4; i++) begin
            `CHK("masked sequence", 3'(i % 3), rd_sel)
            rd();
        end
        wr(DCD_CMD_MASK_NX);
        wr(8'h18);
        wr(DCD_CMD_RD_SEQ);
        `CHK("sequence start", 11'h300, {rd_sel, rd_data})
        rd();
        wr(DCD_CMD_RESET);
        `CHK("reset keeps pointer", 3'h4, rd_sel)
        wr(DCD_CMD_RD_STAT);
        `CHK("status select", 3'h0, rd_sel)
        tally_and_finish();
    end
endmodule : test_dcd_top
